// file: hdl/diag_regs_pkg.sv
// package for the socket card configuration register bank
// assumes a 32-bit apb slave, one register per aligned word
`default_nettype none
package diag_regs_pkg;
    // printed offsets are not multiples of four: they are word indexes
    localparam logic [7:0] CARD_CONTROL_IDX = 8'h91;
    localparam logic [7:0] DEVICE_CONTROL_IDX = 8'h92;
    localparam logic [7:0] DIAGNOSTIC_CONTROL_IDX = 8'h93;
    localparam logic [7:0] CARD_CONTROL_RST = 8'h00;
    localparam logic [7:0] DEVICE_CONTROL_RST = 8'h66;
    localparam logic [7:0] DIAGNOSTIC_CONTROL_RST = 8'h60;
    // card control fields
    localparam int RING_OUTPUT_ENABLE_BIT = 7;
    localparam int CARD_AUDIO_ROUTE_BIT = 2;
    localparam int SPEAKER_OUT_ENABLE_BIT = 1;
    localparam int CARD_INTERRUPT_FLAG_BIT = 0;
    // device control fields
    localparam int SOCKET_POWER_HOLD_BIT = 7;
    localparam int LOW_VOLTAGE_FORCE_BIT = 6;
    localparam int DEVICE_RSVD_BIT = 4;
    localparam int INTERRUPT_SELECT_LSB = 1;
    // diagnostic fields
    localparam int ID_MASK_BIT = 7;
    localparam int DIAG_FIXED_ONE_BIT = 6;
    localparam int STATUS_CHANGE_ROUTE_BIT = 5;
    localparam int DELAYED_TXN_OFF_BIT = 4;
    localparam int RETRY_LONG_BIT = 3;
    localparam int CARDBUS_DISCARD_BIT = 2;
    localparam int HOST_DISCARD_BIT = 1;
    // timing counts in cycles
    localparam logic [6:0] RETRY_LATENCY_SHORT = 7'd16;
    localparam logic [6:0] RETRY_LATENCY_LONG = 7'd64;
    localparam logic [15:0] DISCARD_PERIOD_SHORT = 16'h0400;
    localparam logic [15:0] DISCARD_PERIOD_LONG = 16'h8000;
    typedef enum logic [1:0] {
        INT_PARALLEL_ONLY = 2'b00,
        INT_RESERVED = 2'b01,
        INT_SERIAL_LEGACY_PARALLEL = 2'b10,
        INT_SERIAL_ALL = 2'b11
    } int_mode_t;
    typedef struct packed {
        logic delayed_txn_off;
        logic [6:0] retry_latency;
        logic [15:0] cardbus_discard_period;
        logic [15:0] host_discard_period;
    } bridge_timing_t;
endpackage : diag_regs_pkg
`default_nettype wire

// file: hdl/socket_card_device_diag_regs.sv
// configuration register bank of a single socket card bridge
// assumes apb master on pclk; global_reset_n is the sticky-bit reset
//
// Design decision made here: the APB slave port.
`default_nettype none
module socket_card_device_diag_regs #(
    parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
    parameter logic [15:0] DEVICE_ID = 16'h5678  // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic global_reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_function_irq,
    input wire logic ring_indicate_in,
    output logic ring_indicate_out,
    output logic ring_indicate_out_oe,
    output logic card_audio_pwm_output,
    output logic card_audio_pwm_oe,
    input wire logic card_audio_in,
    input wire logic card_speaker_input,
    output logic speaker_output_pin,
    output logic speaker_output_pin_oe,
    input wire logic in_d3_state,
    input wire logic socket_power_down_req,
    output logic socket_power_down,
    output logic socket_3v_capable,
    output logic [1:0] interrupt_signaling_select,
    output logic [15:0] vendor_id_read,
    output logic [15:0] device_id_read,
    input wire logic legacy_803_bit4,
    input wire logic [3:0] legacy_805_hi,
    output logic status_change_to_host,
    output diag_regs_pkg::bridge_timing_t bridge_timing
);
    logic [7:0] card_control_r;
    logic [7:0] device_control_r;
    logic [7:0] diagnostic_control_r;
    logic [31:0] prdata_r;
    logic [9:0] word_idx;
    logic wr_en;
    logic rd_en;
    logic lane0;
    logic hit;
    logic flag_clear;

    assign word_idx = paddr[11:2];
    assign hit = (paddr[1:0] == 2'b00) &&
        (word_idx == {2'b00, diag_regs_pkg::CARD_CONTROL_IDX} ||
         word_idx == {2'b00, diag_regs_pkg::DEVICE_CONTROL_IDX} ||
         word_idx == {2'b00, diag_regs_pkg::DIAGNOSTIC_CONTROL_IDX});
    assign wr_en = psel && penable && pwrite && hit;
    assign rd_en = psel && !penable && !pwrite;
    assign lane0 = pstrb[0];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_r;

    assign flag_clear = wr_en && lane0 &&
        word_idx == {2'b00, diag_regs_pkg::CARD_CONTROL_IDX} &&
        pwdata[diag_regs_pkg::CARD_INTERRUPT_FLAG_BIT];

    // card control, sticky bits kept across presetn
    always_ff @(posedge pclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            card_control_r <= diag_regs_pkg::CARD_CONTROL_RST;
        end else begin
            if (wr_en && lane0 &&
                word_idx == {2'b00, diag_regs_pkg::CARD_CONTROL_IDX}) begin
                card_control_r[7:1] <= pwdata[7:1];
            end
            if (card_function_irq) begin
                card_control_r[0] <= 1'b1;
            end else if (flag_clear) begin
                card_control_r[0] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            device_control_r <= diag_regs_pkg::DEVICE_CONTROL_RST;
        end else if (wr_en && lane0 &&
                     word_idx == {2'b00, diag_regs_pkg::DEVICE_CONTROL_IDX}) begin
            device_control_r <= pwdata[7:0] & 8'hEF;
        end
    end

    always_ff @(posedge pclk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            diagnostic_control_r <= diag_regs_pkg::DIAGNOSTIC_CONTROL_RST;
        end else if (wr_en && lane0 &&
                     word_idx == {2'b00, diag_regs_pkg::DIAGNOSTIC_CONTROL_IDX}) begin
            diagnostic_control_r <= pwdata[7:0] | 8'h40;
        end
    end

    // read data registered in the setup cycle, stands through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            if (!hit) begin
                prdata_r <= 32'h0000_0000;
            end else if (word_idx ==
                         {2'b00, diag_regs_pkg::CARD_CONTROL_IDX}) begin
                prdata_r <= {24'h000000, card_control_r};
            end else if (word_idx ==
                         {2'b00, diag_regs_pkg::DEVICE_CONTROL_IDX}) begin
                prdata_r <= {24'h000000, device_control_r};
            end else if (word_idx ==
                         {2'b00, diag_regs_pkg::DIAGNOSTIC_CONTROL_IDX}) begin
                prdata_r <= {24'h000000, diagnostic_control_r};
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // pin and control outputs
    assign ring_indicate_out_oe =
        card_control_r[diag_regs_pkg::RING_OUTPUT_ENABLE_BIT];
    assign ring_indicate_out = ring_indicate_in;
    assign card_audio_pwm_oe =
        !card_control_r[diag_regs_pkg::CARD_AUDIO_ROUTE_BIT];
    assign card_audio_pwm_output = card_audio_pwm_oe && card_audio_in;
    assign speaker_output_pin_oe =
        card_control_r[diag_regs_pkg::SPEAKER_OUT_ENABLE_BIT];
    assign speaker_output_pin = speaker_output_pin_oe && card_speaker_input;
    assign socket_power_down = socket_power_down_req && !(in_d3_state &&
        device_control_r[diag_regs_pkg::SOCKET_POWER_HOLD_BIT]);
    assign socket_3v_capable =
        device_control_r[diag_regs_pkg::LOW_VOLTAGE_FORCE_BIT];
    assign interrupt_signaling_select = device_control_r[
        diag_regs_pkg::INTERRUPT_SELECT_LSB +: 2];
    assign vendor_id_read = diagnostic_control_r[diag_regs_pkg::ID_MASK_BIT]
        ? 16'hFFFF : VENDOR_ID;
    assign device_id_read = diagnostic_control_r[diag_regs_pkg::ID_MASK_BIT]
        ? 16'hFFFF : DEVICE_ID;
    assign status_change_to_host =
        diagnostic_control_r[diag_regs_pkg::STATUS_CHANGE_ROUTE_BIT]
        ? (legacy_805_hi == 4'h0) : legacy_803_bit4;
    assign bridge_timing.delayed_txn_off =
        diagnostic_control_r[diag_regs_pkg::DELAYED_TXN_OFF_BIT];
    assign bridge_timing.retry_latency =
        diagnostic_control_r[diag_regs_pkg::RETRY_LONG_BIT]
        ? diag_regs_pkg::RETRY_LATENCY_LONG
        : diag_regs_pkg::RETRY_LATENCY_SHORT;
    assign bridge_timing.cardbus_discard_period =
        diagnostic_control_r[diag_regs_pkg::CARDBUS_DISCARD_BIT]
        ? diag_regs_pkg::DISCARD_PERIOD_SHORT
        : diag_regs_pkg::DISCARD_PERIOD_LONG;
    assign bridge_timing.host_discard_period =
        diagnostic_control_r[diag_regs_pkg::HOST_DISCARD_BIT]
        ? diag_regs_pkg::DISCARD_PERIOD_SHORT
        : diag_regs_pkg::DISCARD_PERIOD_LONG;

    chk_flag_set_wins: assert property (@(posedge pclk)
        disable iff (!global_reset_n)
        card_function_irq |=> card_control_r[0])
        else $error("card interrupt flag lost on arrival");
    chk_flag_clear: assert property (@(posedge pclk)
        disable iff (!global_reset_n)
        flag_clear && !card_function_irq |=> !card_control_r[0])
        else $error("card interrupt flag not cleared");
    chk_flag_hold: assert property (@(posedge pclk)
        disable iff (!global_reset_n)
        card_control_r[0] && !flag_clear |=> card_control_r[0])
        else $error("card interrupt flag dropped");
    chk_rsvd_zero: assert property (@(posedge pclk)
        disable iff (!global_reset_n) !device_control_r[4])
        else $error("device control bit 4 not zero");
    chk_fixed_one: assert property (@(posedge pclk)
        disable iff (!global_reset_n) diagnostic_control_r[6])
        else $error("diagnostic bit 6 not one");
    chk_power_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        in_d3_state && device_control_r[7] |-> !socket_power_down)
        else $error("socket powered down under hold");
    chk_ring_enable: assert property (@(posedge pclk)
        disable iff (!presetn)
        ring_indicate_out_oe == card_control_r[7])
        else $error("ring output enable mismatch");
    chk_speaker_gate: assert property (@(posedge pclk)
        disable iff (!presetn)
        !card_control_r[1] |-> !speaker_output_pin_oe && !speaker_output_pin)
        else $error("speaker driven while disabled");
    chk_sticky_keep: assert property (@(posedge pclk)
        disable iff (!global_reset_n)
        $fell(presetn) |-> $stable(device_control_r))
        else $error("sticky bits changed by bus reset");
endmodule : socket_card_device_diag_regs
`default_nettype wire

// file: verif/socket_card_device_diag_regs_bench.sv
// self-checking bench for the socket card configuration register bank
// assumes apb slave whose read data stands during the access phase
`default_nettype none
module socket_card_device_diag_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] VID = 16'h1234; // arbitrary value
    localparam logic [15:0] DID = 16'h5678; // arbitrary value
    localparam logic [11:0] ADR [3] = '{
        {2'b00, diag_regs_pkg::CARD_CONTROL_IDX, 2'b00},
        {2'b00, diag_regs_pkg::DEVICE_CONTROL_IDX, 2'b00},
        {2'b00, diag_regs_pkg::DIAGNOSTIC_CONTROL_IDX, 2'b00}};
    logic pclk = 1'b0, presetn = 1'b0, global_reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, er, card_function_irq = 1'b0;
    logic ring_indicate_in = 1'b0, card_audio_in = 1'b0;
    logic card_speaker_input = 1'b0, in_d3_state = 1'b0;
    logic socket_power_down_req = 1'b0, legacy_803_bit4 = 1'b0;
    logic [3:0] legacy_805_hi = 4'h0;
    logic ring_indicate_out, ring_indicate_out_oe, card_audio_pwm_output;
    logic card_audio_pwm_oe, speaker_output_pin, speaker_output_pin_oe;
    logic socket_power_down, socket_3v_capable, status_change_to_host;
    logic [1:0] interrupt_signaling_select;
    logic [15:0] vendor_id_read, device_id_read;
    diag_regs_pkg::bridge_timing_t bridge_timing;
    logic [7:0] m [3];
    logic [7:0] d;
    int err_count = 0, checked = 0, idx;

    socket_card_device_diag_regs #(.VENDOR_ID(VID), .DEVICE_ID(DID)) u_dut (
        .pclk, .presetn, .global_reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .card_function_irq,
        .ring_indicate_in, .ring_indicate_out, .ring_indicate_out_oe,
        .card_audio_pwm_output, .card_audio_pwm_oe, .card_audio_in,
        .card_speaker_input, .speaker_output_pin, .speaker_output_pin_oe,
        .in_d3_state, .socket_power_down_req, .socket_power_down,
        .socket_3v_capable, .interrupt_signaling_select, .vendor_id_read,
        .device_id_read, .legacy_803_bit4, .legacy_805_hi,
        .status_change_to_host, .bridge_timing);

    always #4 pclk = ~pclk;

    function automatic logic [7:0] nxt(input int i, input logic [7:0] o,
                                       input logic [7:0] v);
        case (i)
            0: nxt = {v[7:1], o[0] & ~v[0]};
            1: nxt = {v[7:5], 1'b0, v[3:0]};
            default: nxt = {v[7], 1'b1, v[5:0]};
        endcase
    endfunction : nxt

    function automatic diag_regs_pkg::bridge_timing_t tim(input logic [7:0] r);
        tim.delayed_txn_off = r[4];
        tim.retry_latency = r[3] ? diag_regs_pkg::RETRY_LATENCY_LONG
                                 : diag_regs_pkg::RETRY_LATENCY_SHORT;
        tim.cardbus_discard_period = r[2] ? diag_regs_pkg::DISCARD_PERIOD_SHORT
                                          : diag_regs_pkg::DISCARD_PERIOD_LONG;
        tim.host_discard_period = r[1] ? diag_regs_pkg::DISCARD_PERIOD_SHORT
                                       : diag_regs_pkg::DISCARD_PERIOD_LONG;
    endfunction : tim

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [7:0] v);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
        end
        er = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input int i, input logic [7:0] v);
        apb(ADR[i], 1'b1, v);
        m[i] = nxt(i, m[i], v);
    endtask : wr

    task automatic rdchk(input int i);
        apb(ADR[i], 1'b0, 8'h00);
        chk(rd, {24'h0, m[i]});
    endtask : rdchk

    task automatic outs;
        {ring_indicate_in, card_audio_in, card_speaker_input, in_d3_state,
         socket_power_down_req, legacy_803_bit4, legacy_805_hi} <= 10'($urandom);
        @(negedge pclk);
        chk({ring_indicate_out_oe, ring_indicate_out, card_audio_pwm_oe,
             card_audio_pwm_output}, {m[0][7], ring_indicate_in, !m[0][2],
             card_audio_in & !m[0][2]});
        chk({speaker_output_pin_oe, speaker_output_pin},
            {m[0][1], card_speaker_input & m[0][1]});
        chk(socket_power_down, socket_power_down_req & !(in_d3_state & m[1][7]));
        chk({socket_3v_capable, interrupt_signaling_select}, m[1][6:4] & 3'h4 | m[1][2:1]);
        chk({vendor_id_read, device_id_read}, m[2][7] ? 32'hFFFFFFFF : {VID, DID});
        chk(status_change_to_host, m[2][5] ? legacy_805_hi == 4'h0 : legacy_803_bit4);
        chk(bridge_timing, tim(m[2]));
        @(posedge pclk);
    endtask : outs

    initial begin
        #200000;
        err_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'h17C53062));
        m = '{diag_regs_pkg::CARD_CONTROL_RST, diag_regs_pkg::DEVICE_CONTROL_RST,
              diag_regs_pkg::DIAGNOSTIC_CONTROL_RST};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        global_reset_n <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 3; i++) rdchk(i);
        outs();
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            wr(1, 8'h10 | 8'(k << 1));
            rdchk(1);
            outs();
        end
        wr(2, 8'h00);
        rdchk(2);
        $display("test corner values done");
        for (int n = 0; n < 40; n++) begin
            idx = $urandom_range(2);
            d = 8'($urandom) & (idx == 0 ? 8'h87 : idx == 1 ? 8'hF6 : 8'hFE);
            wr(idx, d);
            rdchk(idx);
            outs();
        end
        $display("test random writes done");
        card_function_irq <= 1'b1;
        @(posedge pclk);
        card_function_irq <= 1'b0;
        m[0][0] = 1'b1;
        rdchk(0);
        wr(0, m[0] & 8'hFE);
        rdchk(0);
        card_function_irq <= 1'b1;
        wr(0, m[0] | 8'h01);
        card_function_irq <= 1'b0;
        m[0][0] = 1'b1;
        rdchk(0);
        wr(0, m[0] | 8'h01);
        rdchk(0);
        $display("test interrupt flag done");
        apb(12'h250, 1'b1, 8'hFF);
        chk(er, 1'b1);
        apb(12'h245, 1'b0, 8'h00);
        chk({er, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 3; i++) rdchk(i);
        $display("test unmapped access done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 3; i++) rdchk(i);
        global_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        global_reset_n <= 1'b1;
        @(posedge pclk);
        m = '{diag_regs_pkg::CARD_CONTROL_RST, diag_regs_pkg::DEVICE_CONTROL_RST,
              diag_regs_pkg::DIAGNOSTIC_CONTROL_RST};
        for (int i = 0; i < 3; i++) rdchk(i);
        outs();
        $display("test sticky reset done");
        close_out();
    end
endmodule : socket_card_device_diag_regs_bench
`default_nettype wire
